// ==== design/inverter_link_frame_handler.sv ====
`timescale 1ns/1ns
// Functional notes
// [RULE1] - An enquiry character always starts a new request, dropping any partial frame.
// [RULE2] - A reply for an error-free write frame starts with the acknowledge character.
// [RULE3] - A reply for a frame with an error starts with the negative-acknowledge character.
// [RULE4] - The station field is two hex digits 00 to 1F and only frames for this station are answered.
// [RULE5] - Every field is sent as hex digits, each carried as its ASCII code.
// [RULE6] - The reply is held back by the request's wait digit times 10 ms, 0 to 150 ms.
// [RULE7] - The sum check is the low byte of the sum of the covered ASCII codes, as two hex digits, recomputed on receipt.
// [RULE8] - Command codes with the top bit set use the write format with data, the others the read format.
// [RULE9] - A good write gets a short acknowledge, a bad one a negative acknowledge, and a reset gets no reply.
// [RULE10] - The host answers a read reply with acknowledge or negative acknowledge, and writes need no answer.
// [RULE11] - A negative acknowledge from the host makes the station send the same read data again.
// [RULE12] - Consecutive data errors beyond the allowed count stop the drive and raise the link alarm.
// [RULE13] - Retries are up to the host, and too many of them halt the station with the link alarm.
// [RULE14] - Frames end in nothing, CR, or CR LF as configured, and replies end the same way.
// [RULE15] - The command code selects the function and how the data field is decoded.
// [RULE16] - A good read reply wraps its data in start and end of text, then sum check and terminator.
// [RULE17] - The sum check covers everything after the leading control character up to the sum digits.
module inverter_link_frame_handler
   import link_frame_pkg::*;
#(
   parameter int WAIT_STEP_CYCLES = WAIT_STEP_CYC,
   parameter int FIFO_DEPTH       = RX_FIFO_DEPTH
) (
   input  wire logic        CLK,
   input  wire logic        RESET,
   input  wire logic [4:0]  STATION,
   input  wire logic [1:0]  TERM_MODE,
   input  wire logic [3:0]  ALLOW_RETRY,
   input  wire logic        RX_VALID,
   output logic             RX_READY,
   input  wire logic [7:0]  RX_DATA,
   output logic             TX_VALID,
   input  wire logic        TX_READY,
   output logic      [7:0]  TX_DATA,
   output logic             REQ_VALID,
   output request_t         REQ,
   input  wire logic [15:0] RD_DATA,
   output logic             OPTION_COMM_ALARM,
   output logic             DRIVE_STOP
);
   typedef enum logic [8:0] {
      ST_IDLE   = 9'h001,
      ST_HDR    = 9'h002,
      ST_DATA   = 9'h004,
      ST_SUM    = 9'h008,
      ST_TERM   = 9'h010,
      ST_EVAL   = 9'h020,
      ST_WAIT   = 9'h040,
      ST_SEND   = 9'h080,
      ST_ANSWER = 9'h100
   } state_t;

   state_t      state_reg, state_next;
   logic [3:0]  cnt_reg, cnt_next;
   logic [7:0]  rsum_reg, rsum_next;
   logic [7:0]  csum_reg, csum_next;
   logic [19:0] hdr_reg, hdr_next;
   logic [15:0] data_reg, data_next;
   logic        err_reg, err_next;
   logic [3:0]  ecode_reg, ecode_next;
   reply_t      reply_reg, reply_next;
   logic [15:0] rdata_reg, rdata_next;
   logic [3:0]  errcnt_reg, errcnt_next;
   logic        alarm_reg, alarm_next;
   logic [3:0]  pos_reg, pos_next;
   logic [7:0]  tsum_reg, tsum_next;
   logic [7:0]  txb_reg, txb_next;
   logic        ans_nak_reg, ans_nak_next;
   logic        reqv_reg, reqv_next;
   request_t    req_reg, req_next;
   logic        timer_start;
   logic        timer_done;
   logic        fifo_valid;
   logic        rx_take;
   logic [7:0]  rx_byte;

   function automatic logic [3:0] body_len(input reply_t k);
      return (k == RPL_READ) ? READ_BODY : (k == RPL_NAK) ? NAK_BODY : ACK_BODY;
   endfunction

   function automatic logic [7:0] reply_byte(input reply_t k, input logic [3:0] p, input logic [7:0] s,
                                             input logic [15:0] d, input logic [3:0] e,
                                             input logic [4:0] stn, input logic [1:0] tm);
      logic [7:0] b;
      b = 8'h00;
      if (p == 4'h0)
         b = (k == RPL_READ) ? CH_STX : (k == RPL_NAK) ? CH_NAK : CH_ACK; // [RULE2] [RULE3] [RULE16]
      else if (p == 4'h1)
         b = to_hex({3'h0, stn[4]}); // [RULE5]
      else if (p == 4'h2)
         b = to_hex(stn[3:0]);
      else if (p < body_len(k))
      begin
         if (k == RPL_NAK)
            b = to_hex(e);
         else if (p == READ_ETX_POS)
            b = CH_ETX; // [RULE16]
         else if (p == READ_SUM_HI)
            b = to_hex(s[7:4]); // [RULE7]
         else if (p == READ_SUM_LO)
            b = to_hex(s[3:0]);
         else
            b = to_hex(d[4'(15 - 4 * (p - 4'h3)) -: 4]);
      end
      else
         b = (p == body_len(k) && tm != TERM_NONE) ? CH_CR : CH_LF; // [RULE14]
      return b;
   endfunction

   rx_byte_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (CLK),
      .reset     (RESET),
      .in_valid  (RX_VALID),
      .in_ready  (RX_READY),
      .in_data   (RX_DATA),
      .out_valid (fifo_valid),
      .out_ready (rx_take),
      .out_data  (rx_byte)
   );

   reply_wait_timer #(.STEP_CYCLES(WAIT_STEP_CYCLES)) u_wait (
      .clk   (CLK),
      .reset (RESET),
      .start (timer_start),
      .steps (hdr_reg[3:0]),
      .done  (timer_done)
   );

   wire         rx_state  = state_reg inside {ST_IDLE, ST_HDR, ST_DATA, ST_SUM, ST_TERM, ST_ANSWER};
   assign rx_take = fifo_valid && rx_state;
   wire         is_enq    = rx_byte == CH_ENQ;
   wire [3:0]   nib       = hex_val(rx_byte);
   wire         bad_char  = !hex_ok(rx_byte); // [RULE5]
   wire [3:0]   cnt_inc   = cnt_reg + 4'h1;
   wire [7:0]   sum_add   = rsum_reg + rx_byte; // [RULE7] [RULE17]
   wire [19:0]  hdr_shift = {hdr_reg[15:0], nib};
   wire [3:0]   tlen      = term_len(TERM_MODE);
   wire [7:0]   stn_field = hdr_reg[19:12];
   wire [7:0]   cmd_field = hdr_reg[11:4];
   wire         own_stn   = stn_field <= STATION_LIMIT && stn_field[4:0] == STATION; // [RULE4]
   wire         sum_bad   = rsum_reg != csum_reg; // [RULE7]
   wire         is_reset  = cmd_field == CMD_RESET; // [RULE15]
   wire [7:0]   term_exp  = (cnt_reg == 4'h0) ? CH_CR : CH_LF; // [RULE14]
   wire [3:0]   last_pos  = body_len(reply_reg) + tlen - 4'h1;
   wire [3:0]   ans_last  = ANS_CHARS + tlen - 4'h1;
   wire         covered   = reply_reg == RPL_READ && pos_reg != 4'h0 && pos_reg <= READ_ETX_POS; // [RULE17]
   wire [3:0]   errcnt_up = (errcnt_reg == 4'hf) ? errcnt_reg : errcnt_reg + 4'h1;
   wire         too_many  = errcnt_reg > ALLOW_RETRY; // [RULE12] [RULE13]

   always_comb
   begin
      state_next   = state_reg;
      cnt_next     = cnt_reg;
      rsum_next    = rsum_reg;
      csum_next    = csum_reg;
      hdr_next     = hdr_reg;
      data_next    = data_reg;
      err_next     = err_reg;
      ecode_next   = ecode_reg;
      reply_next   = reply_reg;
      rdata_next   = rdata_reg;
      errcnt_next  = errcnt_reg;
      alarm_next   = alarm_reg | too_many; // [RULE12]
      pos_next     = pos_reg;
      tsum_next    = tsum_reg;
      ans_nak_next = ans_nak_reg;
      reqv_next    = 1'b0;
      req_next     = req_reg;
      timer_start  = 1'b0;
      if (rx_take && is_enq)
      begin
         state_next = ST_HDR; // [RULE1]
         cnt_next   = 4'h0;
         rsum_next  = 8'h00;
         err_next   = 1'b0;
         data_next  = 16'h0000;
      end
      else if (rx_take)
      begin
         cnt_next = cnt_inc;
         unique case (state_reg)
            ST_HDR, ST_DATA:
            begin
               rsum_next = sum_add;
               err_next  = err_reg | bad_char;
               if (state_reg == ST_HDR)
                  hdr_next = hdr_shift;
               else
                  data_next = {data_reg[11:0], nib};
               if (state_reg == ST_HDR && cnt_reg == HDR_LAST)
               begin
                  cnt_next   = 4'h0;
                  state_next = hdr_shift[4 + CMD_WRITE_BIT] ? ST_DATA : ST_SUM; // [RULE8]
               end
               else if (state_reg == ST_DATA && cnt_reg == DATA_LAST)
               begin
                  cnt_next   = 4'h0;
                  state_next = ST_SUM;
               end
            end
            ST_SUM:
            begin
               csum_next = {csum_reg[3:0], nib};
               err_next  = err_reg | bad_char;
               if (cnt_reg == SUM_LAST)
               begin
                  cnt_next   = 4'h0;
                  state_next = (tlen == 4'h0) ? ST_EVAL : ST_TERM;
               end
            end
            ST_TERM:
            begin
               if (rx_byte != term_exp)
               begin
                  err_next   = 1'b1; // [RULE14]
                  ecode_next = ERR_TERM;
               end
               if (cnt_inc == tlen)
                  state_next = ST_EVAL;
            end
            ST_ANSWER:
            begin
               if (cnt_reg == 4'h0)
               begin
                  cnt_next     = (rx_byte == CH_ACK || rx_byte == CH_NAK) ? 4'h1 : 4'h0; // [RULE10]
                  ans_nak_next = rx_byte == CH_NAK;
               end
               else if (cnt_reg == ans_last)
               begin
                  cnt_next    = 4'h0;
                  state_next  = ans_nak_reg ? ST_SEND : ST_IDLE; // [RULE11]
                  pos_next    = 4'h0;
                  tsum_next   = 8'h00;
                  errcnt_next = ans_nak_reg ? errcnt_up : 4'h0; // [RULE12]
               end
            end
            default: cnt_next = 4'h0;
         endcase
         if (state_reg inside {ST_HDR, ST_DATA, ST_SUM} && bad_char && !err_reg)
            ecode_next = ERR_CHAR;
      end
      else
      begin
         unique case (state_reg)
            ST_EVAL:
            begin
               state_next = ST_IDLE;
               if (own_stn && !alarm_reg)
               begin
                  if (err_reg || sum_bad)
                  begin
                     reply_next  = RPL_NAK; // [RULE9]
                     ecode_next  = err_reg ? ecode_reg : ERR_SUM;
                     errcnt_next = errcnt_up; // [RULE13]
                     state_next  = ST_WAIT;
                     timer_start = 1'b1;
                  end
                  else
                  begin
                     errcnt_next = 4'h0;
                     reqv_next   = 1'b1; // [RULE15]
                     req_next    = '{write: cmd_field[CMD_WRITE_BIT], code: cmd_field, data: data_reg};
                     reply_next  = cmd_field[CMD_WRITE_BIT] ? RPL_ACK : RPL_READ; // [RULE8]
                     state_next  = is_reset ? ST_IDLE : ST_WAIT; // [RULE9]
                     timer_start = !is_reset;
                  end
               end
            end
            ST_WAIT:
               if (timer_done)
               begin
                  state_next = ST_SEND; // [RULE6]
                  pos_next   = 4'h0;
                  tsum_next  = 8'h00;
                  if (reply_reg == RPL_READ)
                     rdata_next = RD_DATA;
               end
            ST_SEND:
               if (TX_READY)
               begin
                  tsum_next = tsum_reg + (covered ? txb_reg : 8'h00); // [RULE7]
                  pos_next  = pos_reg + 4'h1;
                  if (pos_reg == last_pos)
                  begin
                     state_next = (reply_reg == RPL_READ) ? ST_ANSWER : ST_IDLE;
                     cnt_next   = 4'h0;
                  end
               end
            default: state_next = state_reg;
         endcase
      end
      txb_next = reply_byte(reply_next, pos_next, tsum_next, rdata_next, ecode_next, STATION, TERM_MODE);
   end

   always_ff @(posedge CLK)
   begin
      if (RESET)
      begin
         state_reg   <= ST_IDLE;
         cnt_reg     <= 4'h0;
         rsum_reg    <= 8'h00;
         csum_reg    <= 8'h00;
         hdr_reg     <= 20'h00000;
         data_reg    <= 16'h0000;
         err_reg     <= 1'b0;
         ecode_reg   <= 4'h0;
         reply_reg   <= RPL_ACK;
         rdata_reg   <= 16'h0000;
         errcnt_reg  <= 4'h0;
         alarm_reg   <= 1'b0;
         pos_reg     <= 4'h0;
         tsum_reg    <= 8'h00;
         txb_reg     <= 8'h00;
         ans_nak_reg <= 1'b0;
         reqv_reg    <= 1'b0;
         req_reg     <= '0;
      end
      else
      begin
         state_reg   <= state_next;
         cnt_reg     <= cnt_next;
         rsum_reg    <= rsum_next;
         csum_reg    <= csum_next;
         hdr_reg     <= hdr_next;
         data_reg    <= data_next;
         err_reg     <= err_next;
         ecode_reg   <= ecode_next;
         reply_reg   <= reply_next;
         rdata_reg   <= rdata_next;
         errcnt_reg  <= errcnt_next;
         alarm_reg   <= alarm_next;
         pos_reg     <= pos_next;
         tsum_reg    <= tsum_next;
         txb_reg     <= txb_next;
         ans_nak_reg <= ans_nak_next;
         reqv_reg    <= reqv_next;
         req_reg     <= req_next;
      end
   end

   assign TX_VALID          = state_reg == ST_SEND;
   assign TX_DATA           = txb_reg;
   assign REQ_VALID         = reqv_reg;
   assign REQ               = req_reg;
   assign OPTION_COMM_ALARM = alarm_reg; // [RULE12]
   assign DRIVE_STOP        = alarm_reg;

   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);

   sequence s_nak_answer_done;
      state_reg == ST_ANSWER && rx_take && !is_enq && cnt_reg == ans_last && ans_nak_reg;
   endsequence
   sequence s_resend_start;
      state_reg == ST_SEND && pos_reg == 4'h0 && rdata_reg == $past(rdata_reg);
   endsequence

   chk_enq_restart : assert property (rx_take && is_enq |=> state_reg == ST_HDR && cnt_reg == 4'h0) // [RULE1]
      else $error("enquiry did not restart frame");
   chk_ack_lead : assert property (TX_VALID && pos_reg == 4'h0 && reply_reg == RPL_ACK |-> TX_DATA == CH_ACK) // [RULE2]
      else $error("ack reply lead wrong");
   chk_nak_lead : assert property (TX_VALID && pos_reg == 4'h0 && reply_reg == RPL_NAK |-> TX_DATA == CH_NAK) // [RULE3]
      else $error("nak reply lead wrong");
   chk_foreign_silent : assert property (state_reg == ST_EVAL && !own_stn |=> state_reg == ST_IDLE [*2]) // [RULE4]
      else $error("foreign station answered");
   chk_station_hex : assert property (TX_VALID && (pos_reg == 4'h1 || pos_reg == 4'h2) |-> hex_ok(TX_DATA)) // [RULE5]
      else $error("station digit not hex");
   chk_sum_digit : assert property (TX_VALID && reply_reg == RPL_READ && pos_reg == READ_SUM_LO // [RULE7]
      |-> TX_DATA == to_hex(tsum_reg[3:0])) else $error("sum digit wrong");
   chk_reset_silent : assert property (state_reg == ST_EVAL && own_stn && !alarm_reg && !err_reg && !sum_bad // [RULE9]
      && is_reset |=> state_reg == ST_IDLE && REQ_VALID) else $error("reset request answered");
   chk_nak_resend : assert property (s_nak_answer_done |=> s_resend_start) // [RULE11]
      else $error("no resend after nak");
   chk_alarm_raise : assert property (too_many |=> OPTION_COMM_ALARM && DRIVE_STOP ##1 OPTION_COMM_ALARM) // [RULE12]
      else $error("alarm not raised");
   chk_term_cr : assert property (TX_VALID && pos_reg == body_len(reply_reg) && TERM_MODE != TERM_NONE // [RULE14]
      |-> TX_DATA == CH_CR) else $error("reply terminator wrong");
endmodule // inverter_link_frame_handler

// ==== design/link_frame_pkg.sv ====
package link_frame_pkg;
   localparam logic [7:0] CH_STX        = 8'h02;
   localparam logic [7:0] CH_ETX        = 8'h03;
   localparam logic [7:0] CH_ENQ        = 8'h05;
   localparam logic [7:0] CH_ACK        = 8'h06;
   localparam logic [7:0] CH_LF         = 8'h0a;
   localparam logic [7:0] CH_CR         = 8'h0d;
   localparam logic [7:0] CH_NAK        = 8'h15;
   localparam logic [7:0] ASCII_ZERO    = 8'h30;
   localparam logic [7:0] ASCII_NINE    = 8'h39;
   localparam logic [7:0] ASCII_A       = 8'h41;
   localparam logic [7:0] ASCII_F       = 8'h46;
   localparam logic [7:0] ASCII_A_OFS   = 8'h37;
   localparam logic [3:0] HEX_TEN       = 4'ha;
   localparam logic [3:0] HEX_LETTER    = 4'h9;
   localparam logic [7:0] STATION_LIMIT = 8'h1f;
   localparam logic [7:0] CMD_RESET     = 8'hfd;
   localparam int         CMD_WRITE_BIT = 7;
   localparam logic [3:0] HDR_LAST      = 4'h4;
   localparam logic [3:0] DATA_LAST     = 4'h3;
   localparam logic [3:0] SUM_LAST      = 4'h1;
   localparam logic [3:0] ANS_CHARS     = 4'h3;
   localparam logic [3:0] ACK_BODY      = 4'h3;
   localparam logic [3:0] NAK_BODY      = 4'h4;
   localparam logic [3:0] READ_BODY     = 4'ha;
   localparam logic [3:0] READ_ETX_POS  = 4'h7;
   localparam logic [3:0] READ_SUM_HI   = 4'h8;
   localparam logic [3:0] READ_SUM_LO   = 4'h9;
   localparam logic [3:0] ERR_CHAR      = 4'h1;
   localparam logic [3:0] ERR_SUM       = 4'h2;
   localparam logic [3:0] ERR_TERM      = 4'h3;
   localparam logic [1:0] TERM_NONE     = 2'h0;
   localparam logic [1:0] TERM_CR       = 2'h1;
   localparam logic [1:0] TERM_CRLF     = 2'h2;
   localparam int         CLK_PERIOD_NS = 10;
   localparam int         WAIT_STEP_MS  = 10;
   localparam int         WAIT_STEP_CYC = WAIT_STEP_MS * 1000000 / CLK_PERIOD_NS;
   localparam int         RX_FIFO_DEPTH = 32;
   localparam int         BYTE_W        = 8;

   typedef enum logic [1:0] {RPL_ACK = 2'h0, RPL_NAK = 2'h1, RPL_READ = 2'h2} reply_t;

   typedef struct packed {
      logic        write;
      logic [7:0]  code;
      logic [15:0] data;
   } request_t;

   function automatic logic hex_ok(input logic [7:0] c);
      return (c >= ASCII_ZERO && c <= ASCII_NINE) || (c >= ASCII_A && c <= ASCII_F);
   endfunction

   function automatic logic [3:0] hex_val(input logic [7:0] c);
      return (c <= ASCII_NINE) ? c[3:0] : c[3:0] + HEX_LETTER;
   endfunction

   function automatic logic [7:0] to_hex(input logic [3:0] n);
      return (n < HEX_TEN) ? (ASCII_ZERO | {4'h0, n}) : ASCII_A_OFS + {4'h0, n};
   endfunction

   function automatic logic [3:0] term_len(input logic [1:0] mode);
      return (mode == TERM_CRLF) ? 4'h2 : (mode == TERM_CR) ? 4'h1 : 4'h0;
   endfunction
endpackage

// ==== design/reply_wait_timer.sv ====
`timescale 1ns/1ns
module reply_wait_timer #(
   parameter int STEP_CYCLES = 1000000
) (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       start,
   input  wire logic [3:0] steps,
   output logic            done
);
   localparam int TW = $clog2(STEP_CYCLES + 1);
   logic          busy_reg;
   logic [3:0]    steps_reg;
   logic [TW-1:0] tick_reg;
   wire           tick_end = tick_reg == TW'(STEP_CYCLES - 1);

   // Done once the requested number of whole steps has elapsed
   assign done = busy_reg && steps_reg == 4'h0;

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         busy_reg  <= 1'b0;
         steps_reg <= 4'h0;
         tick_reg  <= '0;
      end
      else if (start)
      begin
         busy_reg  <= 1'b1;
         steps_reg <= steps;
         tick_reg  <= '0;
      end
      else if (busy_reg)
      begin
         busy_reg  <= !done;
         tick_reg  <= (tick_end || done) ? '0 : TW'(tick_reg + 1'b1);
         steps_reg <= (tick_end && !done) ? steps_reg - 4'h1 : steps_reg;
      end
   end

   chk_wait_zero_step : assert property (@(posedge clk) disable iff (reset) // [RULE6]
      start && steps == 4'h0 |=> done) else $error("zero wait not immediate");
   chk_wait_no_early : assert property (@(posedge clk) disable iff (reset) // [RULE6]
      start && steps == 4'h1 |=> !done [*2]) else $error("wait ended early");
endmodule // reply_wait_timer

// ==== design/rx_byte_fifo.sv ====
`timescale 1ns/1ns
module rx_byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_reg;
   logic [AW-1:0]    rd_reg;
   logic [AW:0]      count_reg;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   assign in_ready  = count_reg != (AW+1)'(DEPTH);
   assign out_valid = count_reg != '0;
   assign out_data  = mem[rd_reg];

   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_reg] <= in_data;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         wr_reg    <= '0;
         rd_reg    <= '0;
         count_reg <= '0;
      end
      else
      begin
         wr_reg    <= push ? AW'(wr_reg + 1'b1) : wr_reg;
         rd_reg    <= pop ? AW'(rd_reg + 1'b1) : rd_reg;
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // rx_byte_fifo

// ==== verif/inverter_link_frame_handler_tb.sv ====
`timescale 1ns/1ns
module inverter_link_frame_handler_tb;
   import link_frame_pkg::*;
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; $display("Error %0t: %h, want %h", $time, a, b); end end
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic [4:0]  station = 5'h1f;
   logic [1:0]  term = TERM_CR;
   logic [3:0]  allow = 4'h2;
   logic        stall = 1'b0;
   logic [15:0] rd_data = 16'hab9c;
   logic        rx_valid, rx_ready, tx_valid, tx_ready, req_valid, alarm, stop;
   logic [7:0]  rx_data, tx_data;
   request_t    req;
   int          err_total = 0;
   int          checked = 0;
   int          reqs = 0;
   logic [7:0]  e[$];
   always #5 clk = ~clk;
   always @(posedge clk)
      reqs <= reqs + req_valid;
   inverter_link_frame_handler #(.WAIT_STEP_CYCLES(10)) uut (.CLK(clk), .RESET(reset), .STATION(station),
      .TERM_MODE(term), .ALLOW_RETRY(allow), .RX_VALID(rx_valid), .RX_READY(rx_ready), .RX_DATA(rx_data),
      .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_DATA(tx_data), .REQ_VALID(req_valid), .REQ(req),
      .RD_DATA(rd_data), .OPTION_COMM_ALARM(alarm), .DRIVE_STOP(stop));
   link_host_model host (.clk(clk), .stall(stall), .term(term), .rx_ready(rx_ready), .rx_valid(rx_valid),
      .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic hang();
      err_total++;
      conclude();
   endtask
   function automatic void fin();
      if (term != TERM_NONE)
         e.push_back(CH_CR);
      if (term == TERM_CRLF)
         e.push_back(CH_LF);
   endfunction
   task automatic chk_reply();
      int n;
      for (n = 0; n < 3000 && host.got.size() < e.size(); n++)
         @(posedge clk);
      if (n == 3000)
         hang();
      repeat (20) @(posedge clk);
      `CHK(host.got.size(), e.size())
      foreach (e[i])
         `CHK(host.got[i], e[i])
      host.got.delete();
   endtask
   task automatic t_write(input logic [1:0] tm);
      int r;
      term <= tm;
      @(posedge clk);
      r = reqs;
      host.frame(station, 8'h8a, 4'h0, 16'h5a3c, 1'b0);
      e = {CH_ACK, 8'h31, 8'h46};
      fin();
      chk_reply();
      `CHK(reqs, r + 1)
      `CHK(req, {1'b1, 8'h8a, 16'h5a3c})
      $display("Test write done");
   endtask
   task automatic t_bad();
      host.frame(station, 8'h8a, 4'h1, 16'h0001, 1'b1);
      e = {CH_NAK, 8'h31, 8'h46, 8'h32};
      fin();
      chk_reply();
      $display("Test bad sum done");
   endtask
   task automatic t_read();
      logic [7:0] s;
      host.frame(station, 8'h7b, 4'h3, 16'h0000, 1'b0);
      e = {CH_STX, 8'h31, 8'h46, 8'h41, 8'h42, 8'h39, 8'h43, CH_ETX};
      s = 8'h00;
      foreach (e[i])
         s += (i > 0) ? e[i] : 8'h00;
      e = {e, host.hx(s[7:4]), host.hx(s[3:0])};
      fin();
      chk_reply();
      `CHK(host.first_cyc - host.sent_cyc inside {[30:45]}, 1'b1)
      `CHK(req.write, 1'b0)
      host.answer(1'b0);
      chk_reply();
      host.answer(1'b1);
      e.delete();
      chk_reply();
      $display("Test read done");
   endtask
   task automatic t_quiet();
      host.frame(5'h1e, 8'h8a, 4'h0, 16'h1111, 1'b0);
      e.delete();
      chk_reply();
      host.frame(station, CMD_RESET, 4'h0, 16'h0000, 1'b0);
      chk_reply();
      e = {CH_ENQ, 8'h31, 8'h66, 8'h37, 8'h42, 8'h30, 8'h30, 8'h30};
      host.send(e);
      e = {CH_NAK, 8'h31, 8'h46, 8'h31};
      fin();
      chk_reply();
      $display("Test quiet done");
   endtask
   task automatic t_fill();
      int n;
      stall <= 1'b1;
      host.frame(station, 8'h8a, 4'hf, 16'h0002, 1'b0);
      repeat (10) @(posedge clk);
      host.flood(n);
      `CHK(n, 32)
      repeat (300) @(posedge clk);
      `CHK(host.got.size(), 0)
      stall <= 1'b0;
      e = {CH_ACK, 8'h31, 8'h46};
      fin();
      chk_reply();
      repeat (40) @(posedge clk);
      `CHK(rx_ready, 1'b1)
      $display("Test fill done");
   endtask
   task automatic t_alarm();
      t_bad();
      t_bad();
      `CHK(alarm, 1'b0)
      t_bad();
      `CHK({alarm, stop}, 2'b11)
      host.frame(station, 8'h8a, 4'h0, 16'h0001, 1'b0);
      e.delete();
      chk_reply();
      $display("Test alarm done");
   endtask
   initial
   begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      t_write(TERM_NONE);
      t_write(TERM_CRLF);
      t_write(TERM_CR);
      t_bad();
      t_read();
      t_quiet();
      t_fill();
      t_alarm();
      conclude();
   end
endmodule  // inverter_link_frame_handler_tb

// ==== verif/link_host_model.sv ====
`timescale 1ns/1ns
module link_host_model
   import link_frame_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       stall,
   input  wire logic [1:0] term,
   input  wire logic       rx_ready,
   output logic            rx_valid,
   output logic      [7:0] rx_data,
   input  wire logic       tx_valid,
   output logic            tx_ready,
   input  wire logic [7:0] tx_data
);
   logic [7:0] got[$];
   int         cyc = 0;
   int         sent_cyc;
   int         first_cyc;
   initial {rx_valid, rx_data} = 9'h000;
   assign tx_ready = !stall;
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (tx_valid && tx_ready)
      begin
         if (got.size() == 0)
            first_cyc <= cyc;
         got.push_back(tx_data);
      end
   end
   function automatic logic [7:0] hx(input logic [3:0] n);
      return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
   endfunction
   // Holds the byte until an edge sees ready
   task automatic put(input logic [7:0] b, input int lim, output logic ok);
      rx_valid <= 1'b1;
      rx_data <= b;
      ok = 1'b0;
      for (int n = 0; n < lim && !ok; n++)
      begin
         @(posedge clk);
         ok = rx_ready;
      end
      sent_cyc = cyc;
   endtask
   task automatic send(input logic [7:0] q[$]);
      logic ok;
      if (term != TERM_NONE)
         q.push_back(CH_CR);
      if (term == TERM_CRLF)
         q.push_back(CH_LF);
      foreach (q[i])
      begin
         put(q[i], 5000, ok);
         if (!ok)
            inverter_link_frame_handler_tb.hang();
      end
      rx_valid <= 1'b0;
      rx_data <= ~q[q.size() - 1];
   endtask
   task automatic frame(input logic [4:0] st, input logic [7:0] cmd, input logic [3:0] wt,
                        input logic [15:0] d, input logic bad);
      logic [7:0] q[$];
      logic [7:0] s;
      q = {hx({3'h0, st[4]}), hx(st[3:0]), hx(cmd[7:4]), hx(cmd[3:0]), hx(wt)};
      if (cmd[7])
         q = {q, hx(d[15:12]), hx(d[11:8]), hx(d[7:4]), hx(d[3:0])};
      s = {7'h00, bad};
      foreach (q[i])
         s += q[i];
      q = {CH_ENQ, q, hx(s[7:4]), hx(s[3:0])};
      send(q);
   endtask
   task automatic answer(input logic good);
      logic [7:0] q[$];
      q = {good ? CH_ACK : CH_NAK, 8'h30, 8'h30};
      send(q);
   endtask
   // Pushes filler until the buffer refuses
   task automatic flood(output int n);
      logic ok;
      ok = 1'b1;
      for (n = 0; ok && n < 40; n++)
         put(ASCII_ZERO, 1, ok);
      n--;
      rx_valid <= 1'b0;
      rx_data <= 8'hcf;
   endtask
endmodule  // link_host_model
